// File: common/iam_pkg.sv
// Constants, types and register map of the IPv4 access rule header matcher
package iam_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CTRL_W = 15;
  localparam int unsigned PROTO_W = 8;
  localparam int unsigned TTL_W = 8;
  localparam int unsigned IHL_W = 4;
  localparam int unsigned FRAG_W = 13;
  localparam int unsigned RES_W = 5;
  localparam int unsigned HTRANS_ACT = 1;

  localparam logic [DATA_W-1:0] REG_CTRL     = 32'h0000_0000;
  localparam logic [DATA_W-1:0] REG_PROTO    = 32'h0000_0004;
  localparam logic [DATA_W-1:0] REG_SRC_ADDR = 32'h0000_0008;
  localparam logic [DATA_W-1:0] REG_SRC_MASK = 32'h0000_000c;
  localparam logic [DATA_W-1:0] REG_DST_ADDR = 32'h0000_0010;
  localparam logic [DATA_W-1:0] REG_DST_MASK = 32'h0000_0014;
  localparam logic [DATA_W-1:0] REG_STATUS   = 32'h0000_0018;
  localparam logic [DATA_W-1:0] REG_HIT_CNT  = 32'h0000_001c;

  localparam logic [DATA_W-1:0] RST_ZERO     = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_MASK     = 32'hffff_ffff;
  localparam logic [DATA_W-1:0] HIT_CNT_STEP = 32'h0000_0001;
  localparam logic [CTRL_W-1:0] CTRL_RST     = 15'h0000;
  localparam logic [PROTO_W-1:0] PROTO_RST   = 8'h00;
  localparam logic [RES_W-1:0] RES_RST       = 5'h00;

  localparam logic [PROTO_W-1:0] PROTO_ICMP  = 8'h01;
  localparam logic [PROTO_W-1:0] PROTO_TCP   = 8'h06;
  localparam logic [PROTO_W-1:0] PROTO_UDP   = 8'h11;
  localparam logic [TTL_W-1:0] TTL_ZERO      = 8'h00;
  localparam logic [FRAG_W-1:0] FRAG_ZERO    = 13'h0000;
  localparam logic [IHL_W-1:0] IHL_NO_OPT    = 4'h5;
  localparam logic [2:0] SIZE_WORD           = 3'h2;
  localparam logic HRESP_OKAY                = 1'b0;

  typedef enum logic [1:0] {
    FT_ANY = 2'h0, FT_IPV4 = 2'h1, FT_IPV6 = 2'h2, FT_OTHER = 2'h3
  } iam_ftype_t;
  typedef enum logic [2:0] {
    PS_ANY = 3'h0, PS_SPEC = 3'h1, PS_ICMP = 3'h2, PS_UDP = 3'h3, PS_TCP = 3'h4
  } iam_proto_sel_t;
  typedef enum logic [1:0] {
    TRI_ANY = 2'h0, TRI_NO = 2'h1, TRI_YES = 2'h2
  } iam_tri_t;
  typedef enum logic [1:0] {
    AS_ANY = 2'h0, AS_HOST = 2'h1, AS_NET = 2'h2
  } iam_addr_sel_t;

  typedef struct packed {
    iam_addr_sel_t  dst;
    iam_addr_sel_t  src;
    iam_tri_t       opt;
    iam_tri_t       frag;
    iam_tri_t       ttl;
    iam_proto_sel_t proto;
    iam_ftype_t     ftype;
  } iam_ctrl_t;

  typedef struct packed {
    logic               valid;
    logic               is_ipv4;
    logic [IHL_W-1:0]   ihl;
    logic [TTL_W-1:0]   ttl;
    logic [PROTO_W-1:0] proto;
    logic               more_fragments_bit;
    logic [FRAG_W-1:0]  fragment_position_field;
    logic [DATA_W-1:0]  source_addr;
    logic [DATA_W-1:0]  dest_addr;
  } iam_frame_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic icmp_en;
    logic udp_en;
    logic tcp_en;
  } iam_result_t;
endpackage

// File: rtl/iam_addr_cmp.sv
// Address criterion compare: any, exact host or masked network
`timescale 1ns/1ns
module iam_addr_cmp #(
  parameter int unsigned W = 32
) (
  input  wire iam_pkg::iam_addr_sel_t sel,
  input  wire logic [W-1:0]           frame_addr,
  input  wire logic [W-1:0]           cfg_addr,
  input  wire logic [W-1:0]           cfg_mask,
  output logic                        ok
);
  import iam_pkg::*;

  always_comb begin
    case (sel)
      AS_HOST: begin
        ok = (frame_addr == cfg_addr);
      end
      AS_NET: begin
        // Mask one compares the bit, zero ignores it
        ok = (((frame_addr ^ cfg_addr) & cfg_mask) == '0);
      end
      default: begin
        // Reserved code behaves as any
        ok = 1'b1;
      end
    endcase
  end
endmodule

// File: rtl/iam_matcher.sv
// IPv4 header matcher for one access rule entry, with AHB-Lite registers
`timescale 1ns/1ns
//
// Summary of operation
// - IPv4 header criteria apply only when entry frame type is IPv4.
// - Protocol any ignores the IPv4 protocol field.
// - Protocol specific requires frame protocol equal to configured eight-bit value.
// - ICMP, UDP, TCP selections restrict protocol and enable their extra parameters.
// - TTL zero: frames with TTL above zero never hit.
// - TTL non-zero: only TTL above zero qualifies; any ignores TTL.
// - Fragment no: frames with more-fragments bit or non-zero offset never hit.
// - Fragment yes: only fragmented frames qualify; any ignores fragmentation.
// - Options no: frames indicating IP options never hit.
// - Options yes: only frames with options qualify; any ignores options.
// - Source any ignores the source address.
// - Source host requires exact 32-bit source address equality.
// - Source network compares source address only over source mask bits.
// - Destination any ignores the destination address.
// - Destination host requires exact destination address equality.
// - Destination network compares only over destination mask bits.
module iam_matcher (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  input  wire iam_pkg::iam_frame_t   frame,
  output iam_pkg::iam_result_t       result
);
  import iam_pkg::*;

  iam_ctrl_t           ctrl_q;
  iam_ctrl_t           ctrl_d;
  logic [PROTO_W-1:0]  proto_val_q;
  logic [PROTO_W-1:0]  proto_val_d;
  logic [DATA_W-1:0]   src_addr_q;
  logic [DATA_W-1:0]   src_addr_d;
  logic [DATA_W-1:0]   src_mask_q;
  logic [DATA_W-1:0]   src_mask_d;
  logic [DATA_W-1:0]   dst_addr_q;
  logic [DATA_W-1:0]   dst_addr_d;
  logic [DATA_W-1:0]   dst_mask_q;
  logic [DATA_W-1:0]   dst_mask_d;
  logic [DATA_W-1:0]   hit_cnt_q;
  logic [DATA_W-1:0]   wr_addr_q;
  logic [DATA_W-1:0]   hrdata_q;
  logic [DATA_W-1:0]   rd_d;
  logic                wr_pend_q;
  logic                hreadyout_q;
  logic                hresp_q;
  iam_result_t         res_q;

  logic                bus_act;
  logic                ipv4_sel;
  logic                proto_ok;
  logic                ttl_nz;
  logic                frag_seen;
  logic                opt_seen;
  logic                ttl_ok;
  logic                frag_ok;
  logic                opt_ok;
  logic                src_ok;
  logic                dst_ok;
  logic                all_ok;
  logic                hit_now;

  assign hreadyout = hreadyout_q;
  assign hrdata    = hrdata_q;
  assign hresp     = hresp_q;
  assign result    = res_q;

  // Bus slave: address phase capture
  assign bus_act = hsel && hready && htrans[HTRANS_ACT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= RST_ZERO;
    end else begin
      // Narrow writes are dropped; every register is a whole word
      wr_pend_q <= bus_act && hwrite && (hsize == SIZE_WORD);
      wr_addr_q <= haddr;
    end
  end

  // Next register values, applied in the write data phase
  always_comb begin
    ctrl_d      = ctrl_q;
    proto_val_d = proto_val_q;
    src_addr_d  = src_addr_q;
    src_mask_d  = src_mask_q;
    dst_addr_d  = dst_addr_q;
    dst_mask_d  = dst_mask_q;
    if (wr_pend_q) begin
      if (wr_addr_q == REG_CTRL) begin
        ctrl_d = iam_ctrl_t'(hwdata[CTRL_W-1:0]);
      end else if (wr_addr_q == REG_PROTO) begin
        proto_val_d = hwdata[PROTO_W-1:0];
      end else if (wr_addr_q == REG_SRC_ADDR) begin
        src_addr_d = hwdata;
      end else if (wr_addr_q == REG_SRC_MASK) begin
        src_mask_d = hwdata;
      end else if (wr_addr_q == REG_DST_ADDR) begin
        dst_addr_d = hwdata;
      end else if (wr_addr_q == REG_DST_MASK) begin
        dst_mask_d = hwdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q      <= iam_ctrl_t'(CTRL_RST);
      proto_val_q <= PROTO_RST;
      src_addr_q  <= RST_ZERO;
      src_mask_q  <= RST_MASK;
      dst_addr_q  <= RST_ZERO;
      dst_mask_q  <= RST_MASK;
    end else begin
      ctrl_q      <= ctrl_d;
      proto_val_q <= proto_val_d;
      src_addr_q  <= src_addr_d;
      src_mask_q  <= src_mask_d;
      dst_addr_q  <= dst_addr_d;
      dst_mask_q  <= dst_mask_d;
    end
  end

  // Read mux sees next rule register values so a read right after a write is fresh; status and hit count read current values
  always_comb begin
    rd_d = RST_ZERO;
    if (haddr == REG_CTRL) begin
      rd_d[CTRL_W-1:0] = ctrl_d;
    end else if (haddr == REG_PROTO) begin
      rd_d[PROTO_W-1:0] = proto_val_d;
    end else if (haddr == REG_SRC_ADDR) begin
      rd_d = src_addr_d;
    end else if (haddr == REG_SRC_MASK) begin
      rd_d = src_mask_d;
    end else if (haddr == REG_DST_ADDR) begin
      rd_d = dst_addr_d;
    end else if (haddr == REG_DST_MASK) begin
      rd_d = dst_mask_d;
    end else if (haddr == REG_STATUS) begin
      rd_d[RES_W-1:0] = res_q;
    end else if (haddr == REG_HIT_CNT) begin
      rd_d = hit_cnt_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q    <= RST_ZERO;
      hreadyout_q <= 1'b1;
      hresp_q     <= HRESP_OKAY;
    end else begin
      if (bus_act && !hwrite) begin
        hrdata_q <= rd_d;
      end
      hreadyout_q <= 1'b1;
      hresp_q     <= HRESP_OKAY;
    end
  end

  // Header criteria
  function automatic logic tri_ok(input iam_tri_t s, input logic seen);
    case (s)
      TRI_NO:  tri_ok = !seen;
      TRI_YES: tri_ok = seen;
      default: tri_ok = 1'b1;
    endcase
  endfunction

  assign ipv4_sel = (ctrl_q.ftype == FT_IPV4);

  always_comb begin
    case (ctrl_q.proto)
      PS_SPEC: begin
        proto_ok = (frame.proto == proto_val_q);
      end
      PS_ICMP: begin
        proto_ok = (frame.proto == PROTO_ICMP);
      end
      PS_UDP: begin
        proto_ok = (frame.proto == PROTO_UDP);
      end
      PS_TCP: begin
        proto_ok = (frame.proto == PROTO_TCP);
      end
      default: begin
        proto_ok = 1'b1;
      end
    endcase
  end

  assign ttl_nz    = (frame.ttl != TTL_ZERO);
  assign frag_seen = frame.more_fragments_bit ||
                     (frame.fragment_position_field != FRAG_ZERO);
  // Header length above the base means options follow
  assign opt_seen  = (frame.ihl > IHL_NO_OPT);

  assign ttl_ok  = tri_ok(ctrl_q.ttl, ttl_nz);
  assign frag_ok = tri_ok(ctrl_q.frag, frag_seen);
  assign opt_ok  = tri_ok(ctrl_q.opt, opt_seen);

  iam_addr_cmp #(
    .W          (DATA_W)
  ) u_src_cmp (
    .sel        (ctrl_q.src),
    .frame_addr (frame.source_addr),
    .cfg_addr   (src_addr_q),
    .cfg_mask   (src_mask_q),
    .ok         (src_ok)
  );

  iam_addr_cmp #(
    .W          (DATA_W)
  ) u_dst_cmp (
    .sel        (ctrl_q.dst),
    .frame_addr (frame.dest_addr),
    .cfg_addr   (dst_addr_q),
    .cfg_mask   (dst_mask_q),
    .ok         (dst_ok)
  );

  assign all_ok = ipv4_sel && frame.is_ipv4 && proto_ok && ttl_ok &&
                  frag_ok && opt_ok && src_ok && dst_ok;
  assign hit_now = frame.valid && all_ok;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_q <= iam_result_t'(RES_RST);
    end else begin
      res_q.valid   <= frame.valid;
      res_q.hit     <= hit_now;
      res_q.icmp_en <= frame.valid && ipv4_sel && ctrl_q.proto == PS_ICMP;
      res_q.udp_en  <= frame.valid && ipv4_sel && ctrl_q.proto == PS_UDP;
      res_q.tcp_en  <= frame.valid && ipv4_sel && ctrl_q.proto == PS_TCP;
    end
  end

  // A word write to REG_HIT_CNT clears the counter; a hit in the same cycle still counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_cnt_q <= RST_ZERO;
    end else if (wr_pend_q && wr_addr_q == REG_HIT_CNT) begin
      hit_cnt_q <= hit_now ? HIT_CNT_STEP : RST_ZERO;
    end else if (hit_now) begin
      hit_cnt_q <= hit_cnt_q + HIT_CNT_STEP;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_ftype_gate: assert property (
    frame.valid && ctrl_q.ftype != FT_IPV4 |=> !res_q.hit)
    else $error("hit with entry frame type not IPv4");

  a_all_any: assert property (
    frame.valid && frame.is_ipv4 && ctrl_q.ftype == FT_IPV4 &&
    ctrl_q.proto == PS_ANY && ctrl_q.ttl == TRI_ANY &&
    ctrl_q.frag == TRI_ANY && ctrl_q.opt == TRI_ANY &&
    ctrl_q.src == AS_ANY && ctrl_q.dst == AS_ANY
    |=> res_q.hit)
    else $error("all-any IPv4 entry missed a frame");

  a_proto_spec: assert property (
    frame.valid && ctrl_q.proto == PS_SPEC && frame.proto != proto_val_q
    |=> !res_q.hit)
    else $error("hit with wrong specific protocol");

  a_proto_l4: assert property (
    frame.valid && ctrl_q.proto == PS_UDP && frame.proto != PROTO_UDP
    |=> !res_q.hit)
    else $error("UDP entry hit a non-UDP frame");

  a_l4_enable: assert property (
    frame.valid && ipv4_sel && ctrl_q.proto == PS_TCP
    |=> res_q.tcp_en && !res_q.udp_en && !res_q.icmp_en)
    else $error("TCP parameters not enabled");

  a_ttl_zero: assert property (
    frame.valid && ctrl_q.ttl == TRI_NO && frame.ttl != TTL_ZERO
    |=> !res_q.hit)
    else $error("TTL zero entry hit a live frame");

  a_ttl_nonzero: assert property (
    frame.valid && ctrl_q.ttl == TRI_YES && frame.ttl == TTL_ZERO
    |=> !res_q.hit)
    else $error("TTL non-zero entry hit a dead frame");

  a_frag_no: assert property (
    frame.valid && ctrl_q.frag == TRI_NO &&
    (frame.more_fragments_bit || frame.fragment_position_field != FRAG_ZERO)
    |=> !res_q.hit)
    else $error("fragment no entry hit a fragment");

  a_frag_yes: assert property (
    frame.valid && ctrl_q.frag == TRI_YES && !frame.more_fragments_bit &&
    frame.fragment_position_field == FRAG_ZERO |=> !res_q.hit)
    else $error("fragment yes entry hit a whole frame");

  a_opt_no: assert property (
    frame.valid && ctrl_q.opt == TRI_NO && frame.ihl > IHL_NO_OPT
    |=> !res_q.hit)
    else $error("options no entry hit a frame with options");

  a_opt_yes: assert property (
    frame.valid && ctrl_q.opt == TRI_YES && frame.ihl <= IHL_NO_OPT
    |=> !res_q.hit)
    else $error("options yes entry hit a plain frame");

  a_src_host: assert property (
    frame.valid && ctrl_q.src == AS_HOST && frame.source_addr != src_addr_q
    |=> !res_q.hit)
    else $error("source host mismatch hit");

  a_src_net: assert property (
    frame.valid && ctrl_q.src == AS_NET &&
    ((frame.source_addr ^ src_addr_q) & src_mask_q) != RST_ZERO
    |=> !res_q.hit)
    else $error("source network mismatch hit");

  a_dst_host: assert property (
    frame.valid && ctrl_q.dst == AS_HOST && frame.dest_addr != dst_addr_q
    |=> !res_q.hit)
    else $error("destination host mismatch hit");

  a_dst_net: assert property (
    frame.valid && ctrl_q.dst == AS_NET &&
    ((frame.dest_addr ^ dst_addr_q) & dst_mask_q) != RST_ZERO
    |=> !res_q.hit)
    else $error("destination network mismatch hit");

  a_hit_count: assert property (
    res_q.hit |-> $past(frame.valid) && $past(frame.is_ipv4) &&
    hit_cnt_q != RST_ZERO)
    else $error("hit without a valid IPv4 frame or count");

  a_bus_okay: assert property (
    bus_act && !hwrite && haddr == REG_PROTO && !wr_pend_q
    |=> hrdata_q == {{(DATA_W-PROTO_W){1'b0}}, $past(proto_val_q)} &&
    hreadyout && hresp == HRESP_OKAY)
    else $error("protocol register read back wrong");
endmodule

// File: tb/iam_frame_src.sv
// Ingress parser stand-in that presents one header per call
`timescale 1ns/1ns
module iam_frame_src (
  input  wire logic           hclk,
  output iam_pkg::iam_frame_t frame
);
  import iam_pkg::*;
  initial frame = '0;
  // Idle fields flip so a stale header never passes for the last one
  task automatic send(input iam_frame_t f);
    @(posedge hclk);
    frame <= f;
    @(posedge hclk);
    frame <= {1'b0, ~f[$bits(iam_frame_t)-2:0]};
    // Result is registered: it stands during the cycle after the header
    @(posedge hclk);
  endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the IPv4 header matcher
`timescale 1ns/1ns
module testbench;
  import iam_pkg::*;
  localparam iam_frame_t BASE = {1'b1, 1'b1, 4'h5, 8'h40, 8'h06, 1'b0, 13'h0000,
                                 32'h0a00_0001, 32'hc0a8_0101};
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  iam_frame_t  frame;
  iam_result_t result;
  int          fails;
  int          n_tests;
  int          cyc;

  iam_matcher iam_matcher_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .frame(frame), .result(result)
  );
  iam_frame_src iam_frame_src_inst (.hclk(hclk), .frame(frame));

  always #10 hclk = ~hclk;

  task automatic wrap_up();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under 2000 cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address phase held until hready is seen high, then released
  task automatic aph(input logic [31:0] a, input logic w, input logic [2:0] sz);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= sz;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
  endtask

  task automatic wr_sz(input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz);
    aph(a, 1'b1, sz);
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    wr_sz(a, d, SIZE_WORD);
  endtask

  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    aph(a, 1'b0, SIZE_WORD);
    do @(posedge hclk); while (hready !== 1'b1);
    chk(nm, e, hrdata);
    chk("hresp", HRESP_OKAY, hresp);
  endtask

  function automatic logic [31:0] cw(int ft, int pr, int tt, int fr, int op, int sr, int ds);
    return {17'h0, 2'(ds), 2'(sr), 2'(op), 2'(fr), 2'(tt), 3'(pr), 2'(ft)};
  endfunction

  task automatic try(input logic [31:0] c, input iam_frame_t f, input logic e);
    wr(REG_CTRL, c);
    iam_frame_src_inst.send(f);
    chk("result valid", 1'b1, result.valid);
    chk("hit", e, result.hit);
  endtask

  task automatic t_regs();
    rchk("ctrl rst", REG_CTRL, RST_ZERO);
    rchk("src mask rst", REG_SRC_MASK, RST_MASK);
    rchk("hit cnt rst", REG_HIT_CNT, RST_ZERO);
    wr(32'h0000_0020, 32'h1234_5678);
    rchk("unmapped", 32'h0000_0020, RST_ZERO);
    wr(REG_PROTO, 32'h0000_00ff);
    rchk("proto", REG_PROTO, 32'h0000_00ff);
    // Byte-sized write must leave the register alone
    wr_sz(REG_PROTO, 32'h0000_0011, 3'h0);
    rchk("narrow write", REG_PROTO, 32'h0000_00ff);
    chk("idle result", 5'h00, result);
  endtask

  task automatic t_ftype();
    iam_frame_t f;
    f = BASE;
    try(cw(0, 0, 0, 0, 0, 0, 0), f, 1'b0);
    try(cw(2, 0, 0, 0, 0, 0, 0), f, 1'b0);
    try(cw(1, 0, 0, 0, 0, 0, 0), f, 1'b1);
    f.is_ipv4 = 1'b0;
    try(cw(1, 0, 0, 0, 0, 0, 0), f, 1'b0);
  endtask

  task automatic t_proto();
    iam_frame_t f;
    logic [7:0] pn [3];
    pn = '{PROTO_ICMP, PROTO_UDP, PROTO_TCP};
    f = BASE;
    f.proto = 8'hff;
    try(cw(1, 1, 0, 0, 0, 0, 0), f, 1'b1);
    try(cw(1, 0, 0, 0, 0, 0, 0), f, 1'b1);
    // Spare codes of every criterion behave as any
    try(cw(1, 5, 3, 3, 3, 3, 3), f, 1'b1);
    f.proto = 8'hfe;
    try(cw(1, 1, 0, 0, 0, 0, 0), f, 1'b0);
    for (int i = 0; i < 3; i++) begin
      f.proto = pn[i];
      try(cw(1, 2 + i, 0, 0, 0, 0, 0), f, 1'b1);
      chk("l4 enables", 3'h4 >> i, result[2:0]);
      f.proto = pn[(i + 1) % 3];
      try(cw(1, 2 + i, 0, 0, 0, 0, 0), f, 1'b0);
    end
  endtask

  task automatic t_flags();
    iam_frame_t f;
    f = BASE;
    f.ttl = TTL_ZERO;
    try(cw(1, 0, 1, 0, 0, 0, 0), f, 1'b1);
    try(cw(1, 0, 2, 0, 0, 0, 0), f, 1'b0);
    try(cw(1, 0, 0, 0, 0, 0, 0), f, 1'b1);
    f.ttl = 8'h01;
    try(cw(1, 0, 1, 0, 0, 0, 0), f, 1'b0);
    try(cw(1, 0, 2, 0, 0, 0, 0), f, 1'b1);
    f = BASE;
    try(cw(1, 0, 0, 1, 0, 0, 0), f, 1'b1);
    try(cw(1, 0, 0, 2, 0, 0, 0), f, 1'b0);
    f.more_fragments_bit = 1'b1;
    try(cw(1, 0, 0, 1, 0, 0, 0), f, 1'b0);
    try(cw(1, 0, 0, 2, 0, 0, 0), f, 1'b1);
    f = BASE;
    f.fragment_position_field = 13'h0001;
    try(cw(1, 0, 0, 1, 0, 0, 0), f, 1'b0);
    try(cw(1, 0, 0, 0, 0, 0, 0), f, 1'b1);
    f = BASE;
    try(cw(1, 0, 0, 0, 1, 0, 0), f, 1'b1);
    try(cw(1, 0, 0, 0, 2, 0, 0), f, 1'b0);
    f.ihl = 4'h6;
    try(cw(1, 0, 0, 0, 1, 0, 0), f, 1'b0);
    try(cw(1, 0, 0, 0, 2, 0, 0), f, 1'b1);
    try(cw(1, 0, 0, 0, 0, 0, 0), f, 1'b1);
  endtask

  // Same walk for source (s=0) and destination (s=1)
  task automatic t_addr(input int s);
    iam_frame_t f;
    logic [31:0] ra;
    logic [31:0] rm;
    ra = s ? REG_DST_ADDR : REG_SRC_ADDR;
    rm = s ? REG_DST_MASK : REG_SRC_MASK;
    wr(ra, 32'hc0a8_0a05);
    wr(rm, 32'hffff_ff00);
    f = BASE;
    if (s) f.dest_addr = 32'hc0a8_0a05;
    else f.source_addr = 32'hc0a8_0a05;
    try(cw(1, 0, 0, 0, 0, 1 - s, s), f, 1'b1);
    f = f ^ (s ? 100'h1 : 100'h1_0000_0000);
    try(cw(1, 0, 0, 0, 0, 1 - s, s), f, 1'b0);
    try(cw(1, 0, 0, 0, 0, 2 - 2 * s, 2 * s), f, 1'b1);
    f = f ^ (s ? 100'h100 : 100'h100_0000_0000);
    try(cw(1, 0, 0, 0, 0, 2 - 2 * s, 2 * s), f, 1'b0);
    try(cw(1, 0, 0, 0, 0, 0, 0), f, 1'b1);
    wr(rm, 32'h0000_0000);
    try(cw(1, 0, 0, 0, 0, 2 - 2 * s, 2 * s), f, 1'b1);
  endtask

  task automatic t_all();
    iam_frame_t f;
    logic [31:0] c;
    c = cw(1, 4, 2, 1, 1, 2, 2);
    wr(REG_HIT_CNT, 32'h0000_0000);
    f = BASE;
    f.source_addr = 32'hc0a8_0a77;
    f.dest_addr = 32'h0102_0304;
    // Status copies a one-cycle result, so its read address phase overlaps the result cycle after the header
    fork
      try(c, f, 1'b1);
      begin
        repeat (4) @(posedge hclk);
        rchk("status", REG_STATUS, 32'h0000_0019);
      end
    join
    f.ttl = TTL_ZERO;
    try(c, f, 1'b0);
    f.ttl = 8'h40;
    f.ihl = 4'hf;
    try(c, f, 1'b0);
    f.ihl = 4'h5;
    f.proto = PROTO_UDP;
    try(c, f, 1'b0);
    f.proto = PROTO_TCP;
    try(c, f, 1'b1);
    rchk("hit count", REG_HIT_CNT, 32'h0000_0002);
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = '0;
    fails = 0;
    n_tests = 0;
    cyc = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_ftype();
    t_proto();
    t_flags();
    t_addr(0);
    t_addr(1);
    t_all();
    wrap_up();
  end
endmodule
